// ---- common/scsc_pkg.sv ----
// types of the clock select block
// assumes scsc_regs.svh supplies the numeric constants
package scsc_pkg;
    // ----------------------------------------------------------------------
    // clock control register layout
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic fast_source_sel;
        logic fast_sub_sel;
        logic sys_clock_sel;
        logic slow_source_sel;
        logic halt_fast_sub;
        logic [2:0] system_clock_prescale;
    } scsc_cc_t;
    // ----------------------------------------------------------------------
    // clock source currently driving the system clock
    // ----------------------------------------------------------------------
    typedef enum logic [2:0] {
        SCSC_SRC_SLOW_RC = 3'b000,
        SCSC_SRC_SLOW_XTAL = 3'b001,
        SCSC_SRC_FAST_RC = 3'b010,
        SCSC_SRC_FAST_XTAL = 3'b011,
        SCSC_SRC_RESFREQ = 3'b100
    } scsc_src_t;
    // ----------------------------------------------------------------------
    // oscillator control carrier
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic fast_rc_en;
        logic fast_xtal_en;
        logic resfreq_en;
        logic fast_xtal_pins;
        logic slow_xtal_pins;
    } scsc_osc_t;
    // ----------------------------------------------------------------------
    // whole module state
    // ----------------------------------------------------------------------
    typedef struct packed {
        scsc_cc_t cc;
        logic [4:0] trim;
        logic trim_loaded;
        logic halt_resfreq;
        scsc_osc_t osc;
        scsc_src_t src_act;
        logic [2:0] psc_act;
        logic [4:0] cnt;
        logic tick;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } scsc_state_t;
endpackage : scsc_pkg

// ---- common/scsc_regs.svh ----
// register offsets, field positions and reset values of the clock select block
// assumes an APB slave with 32-bit data, one aligned word per register
`ifndef SCSC_REGS_SVH
`define SCSC_REGS_SVH
// --------------------------------------------------------------------------
// register indices and byte addresses
// --------------------------------------------------------------------------
`define SCSC_IDX_CLOCK_CONTROL 12'h0D8
`define SCSC_IDX_FAST_RC_TRIM 12'h0F7
`define SCSC_IDX_AUX_CONTROL 12'h0F8
`define SCSC_ADDR_CLOCK_CONTROL 12'h360
`define SCSC_ADDR_FAST_RC_TRIM 12'h3DC
`define SCSC_ADDR_AUX_CONTROL 12'h3E0
// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define SCSC_BIT_FAST_SOURCE_SEL 7
`define SCSC_BIT_FAST_SUB_SEL 6
`define SCSC_BIT_SYS_CLOCK_SEL 5
`define SCSC_BIT_SLOW_SOURCE_SEL 4
`define SCSC_BIT_HALT_FAST_SUB 3
`define SCSC_BIT_HALT_RESFREQ 1
`define SCSC_TRIM_W 5
// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define SCSC_CLOCK_CONTROL_RST 8'h05
`define SCSC_PRESCALE_DIV1 3'h5
`define SCSC_PRESCALE_MAX_CNT 5'h1F
`define SCSC_TRIM_RST 5'h00
`endif

// ---- dv/scsc_top_test.sv ----
// self-checking bench of the clock select block, driven over apb
// assumes scsc_top and scsc_regs.svh are compiled first; no partner model
`include "scsc_regs.svh"

module scsc_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // signals and bookkeeping
    // ------------------------------------------------------------------
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [4:0] trim_cfg = 5'h00;
    logic [31:0] prdata;
    logic pready, pslverr, rc_en, xtal_en, rf_en, xpins, spins, tick;
    logic [4:0] trim_out;
    logic [2:0] src_sel, prescale;
    logic [31:0] seed = 32'h856E7440;
    logic [33:0] notes[$];
    logic [33:0] note;
    logic [7:0] cc_exp = 8'h05;
    logic [7:0] cc_seq[8] = '{8'hD5, 8'h0D, 8'h2D, 8'hAD, 8'hAD, 8'h7D, 8'h15, 8'h05};
    logic [4:0] trim_seq[4] = '{5'h0F, 5'h10, 5'h00, 5'h00};
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;

    scsc_top scsc_top_i (
        .CLK_I(clk), .RST_N_I(rst_n), .PADDR_I(paddr), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .TRIM_CFG_I(trim_cfg), .FAST_RC_EN_O(rc_en), .FAST_XTAL_EN_O(xtal_en),
        .RESFREQ_EN_O(rf_en), .FAST_XTAL_PINS_O(xpins), .SLOW_XTAL_PINS_O(spins),
        .FAST_OSC_TRIM_O(trim_out), .SRC_SEL_O(src_sel), .PRESCALE_O(prescale),
        .SYSTEM_CLOCK_TICK_O(tick)
    );

    always #25 clk = ~clk;
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic wrap_up();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares = compares + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED at %0t: %s got %0h want %0h", $time, msg, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // guarded update of clock_control, old values decide
    function automatic logic [7:0] cc_next(input logic [7:0] o, input logic [7:0] w);
        logic [7:0] r;
        r = {o[7:3], w[2:0]};
        if (!o[5]) r[7:6] = w[7:6];
        if (!o[3] || o[7]) r[5] = w[5];
        if (o[5]) r[4] = w[4];
        if (!o[5] || o[7]) r[3] = w[3];
        return r;
    endfunction : cc_next

    function automatic logic [2:0] src_of(input logic [7:0] c);
        return !c[5] ? {2'h0, c[4]} : (c[7] ? 3'h4 : {2'h1, c[6]});
    endfunction : src_of

    task automatic apb(input logic [11:0] a, input logic wr, input logic [7:0] d,
                       input logic [7:0] exp, input logic err);
        logic [31:0] r;
        notes.push_back({~wr, err, 24'h000000, exp});
        r = rnd();
        @(posedge clk);
        paddr <= a;
        pwrite <= wr;
        pwdata <= {r[31:8], d};
        psel <= 1'h1;
        @(posedge clk);
        penable <= 1'h1;
        do
        begin
            @(posedge clk);
        end while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic cc_write(input logic [7:0] w);
        cc_exp = cc_next(cc_exp, w);
        apb(`SCSC_ADDR_CLOCK_CONTROL, 1'h1, w, 8'h00, 1'h0);
        apb(`SCSC_ADDR_CLOCK_CONTROL, 1'h0, 8'h00, cc_exp, 1'h0);
        repeat (70) @(posedge clk);
        chk(32'({rc_en, xtal_en, xpins, spins}), 32'({~cc_exp[3] & ~cc_exp[6],
            ~cc_exp[3] & cc_exp[6], cc_exp[6], cc_exp[4]}), "osc");
        chk(32'(src_sel), 32'(src_of(cc_exp)), "source");
        chk(32'(prescale), 32'(cc_exp[2:0]), "prescale");
    endtask : cc_write

    task automatic tick_chk(input int div);
        int n;
        n = 0;
        @(posedge clk iff tick === 1'h1);
        do
        begin
            @(posedge clk);
            n++;
        end while (tick !== 1'h1 && n < 40);
        chk(32'(n), 32'(div), "tick period");
    endtask : tick_chk
    // ------------------------------------------------------------------
    // answer monitor and timeout
    // ------------------------------------------------------------------
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'h1)
        begin
            note = notes.size() > 0 ? notes.pop_front() : 34'h3FFFFFFFF;
            chk(32'(pslverr), 32'(note[32]), "slave error");
            if (note[33])
                chk(prdata, note[31:0], "read data");
        end
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED at %0t: run did not finish", $time);
            wrap_up();
        end
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        trim_cfg <= 5'(rnd());
        trim_seq[3] = 5'(rnd());
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge clk);
        chk(32'(trim_out), 32'(trim_cfg), "trim load");
        chk(32'({rf_en, rc_en, src_sel, prescale}), 32'h000000C5, "reset outputs");
        apb(`SCSC_ADDR_CLOCK_CONTROL, 1'h0, 8'h00, 8'h05, 1'h0);
        apb(`SCSC_ADDR_FAST_RC_TRIM, 1'h0, 8'h00, 8'(trim_cfg), 1'h0);
        apb(12'h004, 1'h0, 8'h00, 8'h00, 1'h1);
        apb(12'h004, 1'h1, 8'hFF, 8'h00, 1'h1);
        foreach (cc_seq[i])
            cc_write(cc_seq[i]);
        for (int i = 0; i < 30; i++)
            cc_write(8'(rnd()));
        for (int c = 0; c < 8; c++)
        begin
            cc_write({cc_exp[7:3], 3'(c)});
            tick_chk(c > 5 ? 1 : 32 >> c);
        end
        apb(`SCSC_ADDR_AUX_CONTROL, 1'h1, 8'hFF, 8'h00, 1'h0);
        apb(`SCSC_ADDR_AUX_CONTROL, 1'h0, 8'h00, 8'h02, 1'h0);
        chk(32'(rf_en), 32'h00000000, "resfreq halted");
        apb(`SCSC_ADDR_AUX_CONTROL, 1'h1, 8'h00, 8'h00, 1'h0);
        repeat (2) @(posedge clk);
        chk(32'(rf_en), 32'h00000001, "resfreq running");
        foreach (trim_seq[i])
        begin
            apb(`SCSC_ADDR_FAST_RC_TRIM, 1'h1, 8'(trim_seq[i]), 8'h00, 1'h0);
            apb(`SCSC_ADDR_FAST_RC_TRIM, 1'h0, 8'h00, 8'(trim_seq[i]), 1'h0);
            chk(32'(trim_out), 32'(trim_seq[i]), "trim out");
        end
        pstrb <= 4'hE;
        apb(`SCSC_ADDR_FAST_RC_TRIM, 1'h1, 8'(~trim_seq[3]), 8'h00, 1'h0);
        pstrb <= 4'hF;
        apb(`SCSC_ADDR_FAST_RC_TRIM, 1'h0, 8'h00, 8'(trim_seq[3]), 1'h0);
        wrap_up();
    end
endmodule : scsc_top_test

// ---- src/scsc_top.sv ----
// clock source selection, oscillator gating, prescaler and fast rc trim
// assumes an APB master on CLK_I and the trim word from flash on TRIM_CFG_I
//
// How it works
// RL1: bit 7 picks fast source: 0 fast sub-clock, 1 resistance-frequency osc.
// RL2: fast source select only accepts writes while system clock select is zero.
// RL3: bit 6 picks fast rc (0) or fast crystal (1) using its pins.
// RL4: fast sub-clock select writes are ignored during fast operation.
// RL5: bit 5 selects system clock: 0 slow clock, 1 chosen fast clock.
// RL6: system clock select changes only when fast halt is zero or source is 1.
// RL7: bit 4 picks slow rc or slow crystal; changes only in fast mode.
// RL8: bit 3 halts fast oscillators; writable only in slow or resfreq mode.
// RL9: prescale codes 000 to 101 divide by 32, 16, 8, 4, 2, 1.
// RL10: prescaler resets to 101; other clock control bits reset to zero.
// RL11: 5-bit trim tunes fast rc: 00h centre, 0Fh highest, 10h lowest.
// RL12: trim comes from the flash configuration word; fast rc nominal 7.3728 MHz.
// RL13: auxiliary bit 1 stops the resistance-frequency osc; clearing restarts it.
// RL14: blocked writes keep the old bit; source switches without runt pulses.
`include "scsc_regs.svh"

module scsc_top (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // apb slave
    input wire logic [11:0] PADDR_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // flash configuration
    input wire logic [4:0] TRIM_CFG_I,
    // oscillator control
    output logic FAST_RC_EN_O,
    output logic FAST_XTAL_EN_O,
    output logic RESFREQ_EN_O,
    output logic FAST_XTAL_PINS_O,
    output logic SLOW_XTAL_PINS_O,
    output logic [4:0] FAST_OSC_TRIM_O,
    // system clock
    output logic [2:0] SRC_SEL_O,
    output logic [2:0] PRESCALE_O,
    output logic SYSTEM_CLOCK_TICK_O
);

    scsc_pkg::scsc_state_t st_reg;
    scsc_pkg::scsc_state_t st_next;

    // ----------------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------------
    logic acc_first;
    logic acc_commit;
    logic hit_cc;
    logic hit_trim;
    logic hit_aux;
    logic wr_lane;

    assign acc_first = PSEL_I && PENABLE_I && !st_reg.pready;
    assign acc_commit = PSEL_I && PENABLE_I && st_reg.pready;
    assign hit_cc = (PADDR_I == `SCSC_ADDR_CLOCK_CONTROL);
    assign hit_trim = (PADDR_I == `SCSC_ADDR_FAST_RC_TRIM);
    assign hit_aux = (PADDR_I == `SCSC_ADDR_AUX_CONTROL);
    assign wr_lane = acc_commit && PWRITE_I && PSTRB_I[0];

    // ----------------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------------
    scsc_pkg::scsc_cc_t wcc;
    scsc_pkg::scsc_src_t src_target;
    logic fast_mode;
    logic resfreq_mode;

    assign wcc = scsc_pkg::scsc_cc_t'(PWDATA_I[7:0]);
    assign fast_mode = st_reg.cc.sys_clock_sel;
    assign resfreq_mode = st_reg.cc.fast_source_sel;

    always_comb
    begin
        st_next = st_reg;
        // source the system clock should run from
        if (!st_reg.cc.sys_clock_sel) //RL5
        begin
            src_target = st_reg.cc.slow_source_sel ? scsc_pkg::SCSC_SRC_SLOW_XTAL
                                                   : scsc_pkg::SCSC_SRC_SLOW_RC;
        end
        else if (st_reg.cc.fast_source_sel) //RL1
        begin
            src_target = scsc_pkg::SCSC_SRC_RESFREQ;
        end
        else if (st_reg.cc.fast_sub_sel) //RL3
        begin
            src_target = scsc_pkg::SCSC_SRC_FAST_XTAL;
        end
        else
        begin
            src_target = scsc_pkg::SCSC_SRC_FAST_RC;
        end

        // apb answer one cycle into the access phase
        st_next.pready = acc_first;
        if (acc_first)
        begin
            st_next.pslverr = !(hit_cc || hit_trim || hit_aux);
            st_next.prdata = 32'h0000_0000;
            if (hit_cc)
            begin
                st_next.prdata[7:0] = st_reg.cc;
            end
            else if (hit_trim)
            begin
                st_next.prdata[4:0] = st_reg.trim; //RL11
            end
            else if (hit_aux)
            begin
                st_next.prdata[`SCSC_BIT_HALT_RESFREQ] = st_reg.halt_resfreq;
            end
        end
        else
        begin
            st_next.pslverr = 1'b0;
        end

        // guarded clock control writes, blocked bits keep their value
        if (wr_lane && hit_cc)
        begin
            if (!fast_mode) //RL2 RL14
            begin
                st_next.cc.fast_source_sel = wcc.fast_source_sel;
                st_next.cc.fast_sub_sel = wcc.fast_sub_sel; //RL4
            end
            if (!st_reg.cc.halt_fast_sub || resfreq_mode) //RL6
            begin
                st_next.cc.sys_clock_sel = wcc.sys_clock_sel;
            end
            if (fast_mode) //RL7
            begin
                st_next.cc.slow_source_sel = wcc.slow_source_sel;
            end
            if (!fast_mode || resfreq_mode) //RL8
            begin
                st_next.cc.halt_fast_sub = wcc.halt_fast_sub;
            end
            st_next.cc.system_clock_prescale = wcc.system_clock_prescale; //RL9
        end

        // trim: flash value after reset, then software
        if (!st_reg.trim_loaded)
        begin
            st_next.trim = TRIM_CFG_I; //RL12
            st_next.trim_loaded = 1'b1;
        end
        else if (wr_lane && hit_trim)
        begin
            st_next.trim = PWDATA_I[4:0]; //RL11
        end

        if (wr_lane && hit_aux)
        begin
            st_next.halt_resfreq = PWDATA_I[`SCSC_BIT_HALT_RESFREQ]; //RL13
        end

        // oscillator gating follows the register contents
        st_next.osc.fast_rc_en = !st_next.cc.halt_fast_sub && !st_next.cc.fast_sub_sel; //RL8
        st_next.osc.fast_xtal_en = !st_next.cc.halt_fast_sub && st_next.cc.fast_sub_sel;
        st_next.osc.fast_xtal_pins = st_next.cc.fast_sub_sel; //RL3
        st_next.osc.slow_xtal_pins = st_next.cc.slow_source_sel; //RL7
        st_next.osc.resfreq_en = !st_next.halt_resfreq; //RL13

        // divider; source and divisor change only at a period boundary
        st_next.tick = (st_reg.cnt == 5'h00);
        if (st_reg.cnt == 5'h00)
        begin
            st_next.src_act = src_target; //RL14
            st_next.psc_act = st_reg.cc.system_clock_prescale;
            st_next.cnt = `SCSC_PRESCALE_MAX_CNT >> st_reg.cc.system_clock_prescale; //RL9
        end
        else
        begin
            st_next.cnt = st_reg.cnt - 5'h01;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            st_reg.cc <= scsc_pkg::scsc_cc_t'(`SCSC_CLOCK_CONTROL_RST); //RL10
            st_reg.trim <= `SCSC_TRIM_RST;
            st_reg.trim_loaded <= 1'b0;
            st_reg.halt_resfreq <= 1'b0;
            st_reg.osc <= 5'b00100;
            st_reg.src_act <= scsc_pkg::SCSC_SRC_SLOW_RC;
            st_reg.psc_act <= `SCSC_PRESCALE_DIV1;
            st_reg.cnt <= 5'h00;
            st_reg.tick <= 1'b0;
            st_reg.pready <= 1'b0;
            st_reg.pslverr <= 1'b0;
            st_reg.prdata <= 32'h0000_0000;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------------
    assign PRDATA_O = st_reg.prdata;
    assign PREADY_O = st_reg.pready;
    assign PSLVERR_O = st_reg.pslverr;
    assign FAST_RC_EN_O = st_reg.osc.fast_rc_en;
    assign FAST_XTAL_EN_O = st_reg.osc.fast_xtal_en;
    assign RESFREQ_EN_O = st_reg.osc.resfreq_en;
    assign FAST_XTAL_PINS_O = st_reg.osc.fast_xtal_pins;
    assign SLOW_XTAL_PINS_O = st_reg.osc.slow_xtal_pins;
    assign FAST_OSC_TRIM_O = st_reg.trim;
    assign SRC_SEL_O = st_reg.src_act;
    assign PRESCALE_O = st_reg.psc_act;
    assign SYSTEM_CLOCK_TICK_O = st_reg.tick;

    // ----------------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------------
    a_fast_sel_lock: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL2
        $past(st_reg.cc.sys_clock_sel) && st_reg.cc.sys_clock_sel
        |-> $stable(st_reg.cc.fast_source_sel))
        else $error("fast source select changed in fast mode");

    a_fast_sub_lock: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL4
        $past(st_reg.cc.sys_clock_sel) |-> $stable(st_reg.cc.fast_sub_sel))
        else $error("fast sub select changed in fast mode");

    a_sys_sel_lock: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL6
        $past(st_reg.cc.halt_fast_sub && !st_reg.cc.fast_source_sel)
        |-> $stable(st_reg.cc.sys_clock_sel))
        else $error("system clock select changed while fast clock halted");

    a_slow_type_lock: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL7
        !$past(st_reg.cc.sys_clock_sel) |-> $stable(st_reg.cc.slow_source_sel))
        else $error("slow source select changed in slow mode");

    a_halt_lock: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL8
        $past(st_reg.cc.sys_clock_sel && !st_reg.cc.fast_source_sel)
        |-> $stable(st_reg.cc.halt_fast_sub))
        else $error("fast halt changed in fast sub-clock mode");

    a_halt_gates: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL8
        st_reg.cc.halt_fast_sub ##1 st_reg.cc.halt_fast_sub
        |-> !FAST_RC_EN_O && !FAST_XTAL_EN_O)
        else $error("fast oscillator running while halted");

    a_reset_value: assert property (@(posedge CLK_I) //RL10
        $rose(RST_N_I) |-> PRESCALE_O == 3'h5 && st_reg.cc == 8'h05)
        else $error("clock control not at reset value");

    a_trim_load: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL12
        $rose(RST_N_I) |=> FAST_OSC_TRIM_O == $past(TRIM_CFG_I))
        else $error("trim not loaded from configuration word");

    a_resfreq_stop: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL13
        wr_lane && hit_aux ##1 1'b1 |-> RESFREQ_EN_O == !$past(PWDATA_I[1]))
        else $error("resistance-frequency enable does not follow its stop bit");

    a_div1_tick: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL9
        PRESCALE_O == 3'h5 ##1 PRESCALE_O == 3'h5 |-> SYSTEM_CLOCK_TICK_O)
        else $error("undivided clock missed a tick");

    a_div32_gap: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL9
        $rose(SYSTEM_CLOCK_TICK_O) && PRESCALE_O == 3'h0 |=> !SYSTEM_CLOCK_TICK_O [*8])
        else $error("divide by 32 ticked too early");

    a_no_runt: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL14
        $changed(SRC_SEL_O) |-> SYSTEM_CLOCK_TICK_O)
        else $error("source switched inside a clock period");

    a_apb_wait: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O ##1 !PREADY_O)
        else $error("apb answer not one wait state");

    a_rc_running: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL3
        st_reg.trim_loaded && !st_reg.cc.halt_fast_sub && !st_reg.cc.fast_sub_sel
        |-> FAST_RC_EN_O && !FAST_XTAL_EN_O)
        else $error("fast rc not running while selected");

    a_xtal_pins: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL3
        FAST_XTAL_PINS_O == st_reg.cc.fast_sub_sel)
        else $error("fast crystal pins disagree with sub-clock select");

    a_slow_pins: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL7
        SLOW_XTAL_PINS_O == st_reg.cc.slow_source_sel)
        else $error("slow crystal pins disagree with slow source select");

    a_resfreq_src: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL1
        st_reg.cnt == 5'h00 && st_reg.cc.sys_clock_sel && st_reg.cc.fast_source_sel
        |=> SRC_SEL_O == 3'b100)
        else $error("resistance-frequency source not taken");

    a_slow_src: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL5
        st_reg.cnt == 5'h00 && !st_reg.cc.sys_clock_sel |=> SRC_SEL_O[2:1] == 2'b00)
        else $error("slow clock not taken");

    a_fast_sub_src: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL3
        st_reg.cnt == 5'h00 && st_reg.cc.sys_clock_sel && !st_reg.cc.fast_source_sel
        |=> SRC_SEL_O == {2'b01, $past(st_reg.cc.fast_sub_sel)})
        else $error("fast sub-clock not taken");

    a_prescale_write: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL9
        wr_lane && hit_cc |=> st_reg.cc.system_clock_prescale == $past(PWDATA_I[2:0]))
        else $error("prescale write lost");

    a_div2_period: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL9
        $rose(SYSTEM_CLOCK_TICK_O) && PRESCALE_O == 3'h4 |=> !SYSTEM_CLOCK_TICK_O ##1 SYSTEM_CLOCK_TICK_O)
        else $error("divide by 2 period wrong");

    a_trim_write: assert property (@(posedge CLK_I) disable iff (!RST_N_I) //RL11
        st_reg.trim_loaded && wr_lane && hit_trim |=> FAST_OSC_TRIM_O == $past(PWDATA_I[4:0]))
        else $error("trim write lost");

    a_err_pair: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        PSLVERR_O |-> PREADY_O)
        else $error("slave error outside the answer cycle");

    c_to_fast: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
        $rose(st_reg.cc.sys_clock_sel));
    c_resfreq: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
        SRC_SEL_O == 3'b100);
    c_psc_change: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
        $changed(PRESCALE_O));
    c_blocked_wr: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
        wr_lane && hit_cc && fast_mode && wcc.fast_sub_sel != st_reg.cc.fast_sub_sel);
    c_div32_tick: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
        $rose(SYSTEM_CLOCK_TICK_O) && PRESCALE_O == 3'h0);

endmodule : scsc_top
